// File: rtl/tlic_top.sv
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps

`include "tlic_map.svh"

module tlic_top
    import tlic_pkg::*;
#(
    parameter int NSRC = 18,
    parameter int IW   = 5
) (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // Register bus
    input  wire tlic_apb_req_t       apb_i,
    output tlic_apb_rsp_t            apb_o,
    // Peripheral events, one-cycle pulses on pclk
    input  wire logic [NSRC-1:0]     src_event,
    // External interrupt pins, asynchronous
    input  wire logic [1:0]          ext_pin,
    // Core sequencer
    input  wire tlic_core_in_t       core_i,
    output tlic_call_t               call_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tlic_state_t       s_r;
    tlic_state_t       s_nxt;
    logic [1:0]        pin_s;
    logic [NSRC-1:0]   en_all;
    logic [NSRC-1:0]   pr_all;
    logic              glob_en;
    logic [NSRC-1:0]   hi_vec;
    logic [NSRC-1:0]   lo_vec;
    logic              hi_found;
    logic              lo_found;
    logic [IW-1:0]     hi_idx;
    logic [IW-1:0]     lo_idx;
    logic              setup;
    logic              wr;
    logic [31:0]       wmask;
    logic [NSRC-1:0]   hw_set;
    logic              take_ok;
    logic              acked;
    logic              return_from_irq_instr_done;
    // Held as a named vector because a literal cannot be bit-selected
    localparam logic [NSRC-1:0] HWCLR_MASK = `TLIC_HWCLR_MASK;

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    tlic_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (ext_pin),
        .dout    (pin_s)
    );

    // ------------------------------------------------------------
    // Request gating
    // ------------------------------------------------------------
    // Global bit gates every per-source enable
    assign glob_en = s_r.en_pri[`TLIC_GLOBAL_BIT];
    assign en_all  = {s_r.en_b, s_r.en_a, s_r.en_pri[6:0]};
    assign pr_all  = {s_r.pr_b, s_r.pr_a, s_r.pr_pri};
    // Disabled flags simply drop out of both vectors
    assign hi_vec  = s_r.pend & en_all & pr_all & {NSRC{glob_en}};
    assign lo_vec  = s_r.pend & en_all & ~pr_all & {NSRC{glob_en}};

    // One encoder per level; lowest source index wins a tie
    tlic_first_set #(
        .N  (NSRC),
        .IW (IW)
    ) u_enc_hi (
        .vec   (hi_vec),
        .found (hi_found),
        .idx   (hi_idx)
    );

    tlic_first_set #(
        .N  (NSRC),
        .IW (IW)
    ) u_enc_lo (
        .vec   (lo_vec),
        .found (lo_found),
        .idx   (lo_idx)
    );

    // ------------------------------------------------------------
    // Bus decode helpers
    // ------------------------------------------------------------
    assign setup = apb_i.psel & ~apb_i.penable;
    assign wr    = apb_i.psel & apb_i.penable & apb_i.pwrite;
    assign wmask = {{8{apb_i.pstrb[3]}}, {8{apb_i.pstrb[2]}},
                    {8{apb_i.pstrb[1]}}, {8{apb_i.pstrb[0]}}};

    // Event sources: peripherals plus rising edges of the pins
    always_comb begin
        hw_set = src_event;
        hw_set[`TLIC_SRC_PIN0] = src_event[`TLIC_SRC_PIN0]
                               | (pin_s[0] & ~s_r.pin_q[0]);
        hw_set[`TLIC_SRC_PIN1] = src_event[`TLIC_SRC_PIN1]
                               | (pin_s[1] & ~s_r.pin_q[1]);
    end

    // Sequencer events
    assign acked     = s_r.call.call_req & core_i.call_ack;
    assign return_from_irq_instr_done = core_i.instr_done & core_i.instr_is_return_from_irq_instr;
    // A return's own completion never launches a call, so one more
    // instruction always runs first
    assign take_ok   = core_i.instr_done & ~core_i.instr_is_return_from_irq_instr
                     & ~s_r.call.call_req;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.pin_q = pin_s;

        // Register writes take effect in the access phase only
        if (wr) begin
            unique case (apb_i.paddr)
                `TLIC_OFS_PEND: begin
                    s_nxt.pend = (s_r.pend & ~wmask[NSRC-1:0])
                               | (apb_i.pwdata[NSRC-1:0] & wmask[NSRC-1:0]);
                end
                `TLIC_OFS_EN_PRI: begin
                    if (apb_i.pstrb[0]) begin
                        s_nxt.en_pri = apb_i.pwdata[7:0];
                    end
                end
                `TLIC_OFS_EN_A: begin
                    if (apb_i.pstrb[0]) begin
                        s_nxt.en_a = apb_i.pwdata[7:0];
                    end
                end
                `TLIC_OFS_EN_B: begin
                    if (apb_i.pstrb[0]) begin
                        s_nxt.en_b = apb_i.pwdata[2:0];
                    end
                end
                `TLIC_OFS_PR_PRI: begin
                    if (apb_i.pstrb[0]) begin
                        s_nxt.pr_pri = apb_i.pwdata[6:0];
                    end
                end
                `TLIC_OFS_PR_A: begin
                    if (apb_i.pstrb[0]) begin
                        s_nxt.pr_a = apb_i.pwdata[7:0];
                    end
                end
                `TLIC_OFS_PR_B: begin
                    if (apb_i.pstrb[0]) begin
                        s_nxt.pr_b = apb_i.pwdata[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Flags that hardware retires when the core vectors
        if (acked && HWCLR_MASK[s_r.call.call_idx]) begin
            s_nxt.pend[s_r.call.call_idx] = 1'b0;
        end

        // Hardware events last: a set beats any clear in the same cycle
        s_nxt.pend = s_nxt.pend | hw_set;

        // Detection stage, refreshed every cycle
        s_nxt.det_hi_v   = hi_found;
        s_nxt.det_lo_v   = lo_found;
        s_nxt.det_hi_idx = hi_idx;
        s_nxt.det_lo_idx = lo_idx;

        // Return closes the most recent service level
        if (return_from_irq_instr_done) begin
            if (s_r.act_hi) begin
                s_nxt.act_hi = 1'b0;
            end else begin
                s_nxt.act_lo = 1'b0;
            end
        end

        // Core has taken the call: level is now in service
        if (acked) begin
            s_nxt.call.call_req = 1'b0;
            if (s_r.call.call_hi) begin
                s_nxt.act_hi = 1'b1;
            end else begin
                s_nxt.act_lo = 1'b1;
            end
        end

        // Decision uses the detection latched a cycle earlier, so a
        // request seen just before an enable clear can still win
        if (take_ok) begin
            if (s_r.det_hi_v && !s_r.act_hi) begin
                s_nxt.call.call_req = 1'b1;
                s_nxt.call.call_hi  = 1'b1;
                s_nxt.call.call_idx = s_r.det_hi_idx;
                s_nxt.call.call_vec = `TLIC_VEC_BASE
                    + (16'(s_r.det_hi_idx) << `TLIC_VEC_SHIFT);
            end else if (s_r.det_lo_v && !s_r.act_hi && !s_r.act_lo) begin
                s_nxt.call.call_req = 1'b1;
                s_nxt.call.call_hi  = 1'b0;
                s_nxt.call.call_idx = s_r.det_lo_idx;
                s_nxt.call.call_vec = `TLIC_VEC_BASE
                    + (16'(s_r.det_lo_idx) << `TLIC_VEC_SHIFT);
            end
        end

        // Read data and error are prepared in the setup phase
        if (setup) begin
            s_nxt.prdata  = 32'h0000_0000;
            s_nxt.pslverr = 1'b0;
            unique case (apb_i.paddr)
                `TLIC_OFS_PEND:   s_nxt.prdata[NSRC-1:0] = s_r.pend;
                `TLIC_OFS_EN_PRI: s_nxt.prdata[7:0] = s_r.en_pri;
                `TLIC_OFS_EN_A:   s_nxt.prdata[7:0] = s_r.en_a;
                `TLIC_OFS_EN_B:   s_nxt.prdata[2:0] = s_r.en_b;
                `TLIC_OFS_PR_PRI: s_nxt.prdata[6:0] = s_r.pr_pri;
                `TLIC_OFS_PR_A:   s_nxt.prdata[7:0] = s_r.pr_a;
                `TLIC_OFS_PR_B:   s_nxt.prdata[2:0] = s_r.pr_b;
                `TLIC_OFS_STAT: begin
                    s_nxt.prdata[0]   = s_r.act_hi;
                    s_nxt.prdata[1]   = s_r.act_lo;
                    s_nxt.prdata[2]   = s_r.call.call_req;
                    s_nxt.prdata[3]   = s_r.call.call_hi;
                    s_nxt.prdata[8:4] = s_r.call.call_idx;
                end
                default:          s_nxt.pslverr = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.pend          <= `TLIC_RST_PEND;
            s_r.en_pri        <= `TLIC_RST_EN8;
            s_r.en_a          <= `TLIC_RST_EN8;
            s_r.en_b          <= `TLIC_RST_EN3;
            s_r.pr_pri        <= `TLIC_RST_PR7;
            s_r.pr_a          <= `TLIC_RST_PR8;
            s_r.pr_b          <= `TLIC_RST_PR3;
            s_r.det_hi_v      <= 1'b0;
            s_r.det_lo_v      <= 1'b0;
            s_r.det_hi_idx    <= '0;
            s_r.det_lo_idx    <= '0;
            s_r.act_hi        <= 1'b0;
            s_r.act_lo        <= 1'b0;
            s_r.call.call_req <= 1'b0;
            s_r.call.call_hi  <= 1'b0;
            s_r.call.call_idx <= '0;
            s_r.call.call_vec <= 16'h0000;
            s_r.pin_q         <= 2'h0;
            s_r.prdata        <= 32'h0000_0000;
            s_r.pslverr       <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait states keep the slave simple; reads show setup-time state
    assign apb_o.prdata  = s_r.prdata;
    assign apb_o.pready  = 1'b1;
    assign apb_o.pslverr = s_r.pslverr & apb_i.psel & apb_i.penable;
    assign call_o        = s_r.call;

endmodule

// File: pkg/tlic_map.svh
`ifndef TLIC_MAP_SVH
`define TLIC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define TLIC_OFS_PEND    8'h00
`define TLIC_OFS_EN_PRI  8'h04
`define TLIC_OFS_EN_A    8'h08
`define TLIC_OFS_EN_B    8'h0c
`define TLIC_OFS_PR_PRI  8'h10
`define TLIC_OFS_PR_A    8'h14
`define TLIC_OFS_PR_B    8'h18
`define TLIC_OFS_STAT    8'h1c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define TLIC_GLOBAL_BIT  7
`define TLIC_RST_PEND    18'h00000
`define TLIC_RST_EN8     8'h00
`define TLIC_RST_EN3     3'h0
`define TLIC_RST_PR7     7'h00
`define TLIC_RST_PR8     8'h00
`define TLIC_RST_PR3     3'h0

// ----------------------------------------------------------------
// Sources, vectors and hardware-cleared flags
// ----------------------------------------------------------------
`define TLIC_SRC_PIN0    0
`define TLIC_SRC_PIN1    2
`define TLIC_HWCLR_MASK  18'h1000f
`define TLIC_VEC_BASE    16'h0003
`define TLIC_VEC_SHIFT   3

`endif

// File: pkg/tlic_pkg.sv
package tlic_pkg;

    // ------------------------------------------------------------
    // Bus and core carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } tlic_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tlic_apb_rsp_t;

    typedef struct packed {
        logic instr_done;
        logic instr_is_return_from_irq_instr;
        logic call_ack;
    } tlic_core_in_t;

    typedef struct packed {
        logic        call_req;
        logic        call_hi;
        logic [4:0]  call_idx;
        logic [15:0] call_vec;
    } tlic_call_t;

    // ------------------------------------------------------------
    // Whole controller state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [17:0] pend;
        logic [7:0]  en_pri;
        logic [7:0]  en_a;
        logic [2:0]  en_b;
        logic [6:0]  pr_pri;
        logic [7:0]  pr_a;
        logic [2:0]  pr_b;
        logic        det_hi_v;
        logic        det_lo_v;
        logic [4:0]  det_hi_idx;
        logic [4:0]  det_lo_idx;
        logic        act_hi;
        logic        act_lo;
        tlic_call_t  call;
        logic [1:0]  pin_q;
        logic [31:0] prdata;
        logic        pslverr;
    } tlic_state_t;

endpackage

// File: rtl/tlic_sync2.sv
`timescale 1ns/1ps

module tlic_sync2 #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    // --------------------------------------------------------
    // Two flops; the first is seen by the second only
    // --------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end

endmodule

// File: rtl/tlic_first_set.sv
`timescale 1ns/1ps

module tlic_first_set #(
    parameter int N  = 18,
    parameter int IW = 5
) (
    // Request vector
    input  wire logic [N-1:0]  vec,
    // Lowest set position
    output logic               found,
    output logic [IW-1:0]      idx
);

    // --------------------------------------------------------
    // Walk downward so the lowest index wins a tie
    // --------------------------------------------------------
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                idx   = IW'(i);
            end
        end
    end

endmodule

// File: verif/tlic_top_props.sv
`timescale 1ns/1ps
module tlic_top_props
    import tlic_pkg::*;
#(
    parameter int NSRC = 18
) (
    // Clock and reset
    input wire logic            pclk,
    input wire logic            presetn,
    // Watched ports
    input wire tlic_apb_req_t   apb_i,
    input wire tlic_apb_rsp_t   apb_o,
    input wire logic [NSRC-1:0] src_event,
    input wire logic [1:0]      ext_pin,
    input wire tlic_core_in_t   core_i,
    input wire tlic_call_t      call_o
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Access phase of a bus transfer
    logic acc;
    assign acc = apb_i.psel && apb_i.penable;

    a_ready_high: assert property (apb_o.pready)
        else $error("pready low");
    a_err_unmapped: assert property (acc && apb_i.paddr > 8'h1c |-> apb_o.pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (acc && apb_i.paddr < 8'h20 && apb_i.paddr[1:0] == 2'h0
        |-> !apb_o.pslverr) else $error("error on mapped access");
    a_call_holds: assert property (call_o.call_req && !core_i.call_ack |=>
        call_o.call_req && $stable(call_o.call_vec) && $stable(call_o.call_hi))
        else $error("call dropped or changed before acknowledge");
    a_ack_drops: assert property (call_o.call_req && core_i.call_ack |=> !call_o.call_req)
        else $error("call still owed after acknowledge");
    a_vec_slot: assert property (call_o.call_req |->
        call_o.call_vec == 16'h0003 + {8'h00, call_o.call_idx, 3'h0})
        else $error("vector not at its eight byte slot");
    a_idx_range: assert property (call_o.call_req |-> call_o.call_idx < 5'h12)
        else $error("source index out of range");
    a_call_cause: assert property ($rose(call_o.call_req) |-> $past(core_i.instr_done))
        else $error("call raised without a completed instruction");
    a_return_from_irq_instr_waits: assert property (core_i.instr_done && core_i.instr_is_return_from_irq_instr
        |=> !$rose(call_o.call_req)) else $error("call taken on the return itself");

    // Main scenarios reached
    c_high_call: cover property ($rose(call_o.call_req) && call_o.call_hi);
    c_return: cover property (core_i.instr_done && core_i.instr_is_return_from_irq_instr);
    c_bus_error: cover property (acc && apb_o.pslverr);
endmodule

bind tlic_top tlic_top_props #(.NSRC(NSRC)) i_tlic_top_props (.pclk(pclk), .presetn(presetn),
    .apb_i(apb_i), .apb_o(apb_o), .src_event(src_event), .ext_pin(ext_pin),
    .core_i(core_i), .call_o(call_o));

// File: verif/tlic_core_model.sv
`timescale 1ns/1ps
module tlic_core_model
    import tlic_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Bench controls
    input  wire logic       slow,
    input  wire logic       return_from_irq_instr_req,
    // Controller side
    input  wire tlic_call_t call_o,
    output tlic_core_in_t   core_i
);
    logic [2:0] cnt_r;
    logic       ret_r;

    // Sequencer: an instruction each cycle, or each fourth when slow; the
    // stream stalls while a call is owed, since the core is busy taking it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_i <= '0;
            cnt_r  <= 3'h0;
            ret_r  <= 1'b0;
        end else begin
            core_i <= '0;
            cnt_r  <= cnt_r + 3'h1;
            if (call_o.call_req) begin
                // Acknowledge once, and only an owed call
                if (!core_i.call_ack && cnt_r >= (slow ? 3'h4 : 3'h1)) begin
                    core_i.call_ack <= 1'b1;
                    cnt_r           <= 3'h0;
                end
            end else if (!slow || cnt_r[1:0] == 2'h3) begin
                core_i.instr_done    <= 1'b1;
                core_i.instr_is_return_from_irq_instr <= ret_r;
                ret_r                <= 1'b0;
            end
            if (return_from_irq_instr_req) begin
                ret_r <= 1'b1;
            end
        end
    end
endmodule

// File: verif/tlic_top_bench.sv
`timescale 1ns/1ps
module tlic_top_bench
    import tlic_pkg::*;
;
    logic          pclk;
    logic          presetn;
    tlic_apb_req_t apb_i;
    tlic_apb_rsp_t apb_o;
    logic [17:0]   src_event;
    logic [1:0]    ext_pin;
    tlic_core_in_t core_i;
    tlic_call_t    call_o;
    logic          slow;
    logic          return_from_irq_instr_req;
    logic [31:0]   q;
    logic          err;
    logic [7:0]    seed;
    logic [4:0]    idx;
    int            waited;
    int            num_errors;
    int            comparisons;

    tlic_top i_tlic_top (.pclk(pclk), .presetn(presetn), .apb_i(apb_i), .apb_o(apb_o),
        .src_event(src_event), .ext_pin(ext_pin), .core_i(core_i), .call_o(call_o));
    tlic_core_model i_tlic_core_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .return_from_irq_instr_req(return_from_irq_instr_req), .call_o(call_o), .core_i(core_i));

    // Clock at 40 MHz
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Flag left after the vectoring edge: a few sources clear in hardware
    function automatic logic [31:0] after_ack(input logic [4:0] i);
        return (i < 5'h4 || i == 5'h10) ? 32'h0 : 32'h1 << i;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus transfer; read data and error are taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb_i <= '{1'b1, 1'b0, wr, a, d, 4'hf};
        @(posedge pclk);
        apb_i.penable <= 1'b1;
        do @(posedge pclk);
        while (apb_o.pready !== 1'b1);
        q   = apb_o.prdata;
        err = apb_o.pslverr;
        apb_i.psel    <= 1'b0;
        apb_i.penable <= 1'b0;
    endtask

    // Global bit goes last, so a call that it releases is still owed when the
    // caller starts to wait for it
    task automatic cfg(input logic g, input logic [17:0] en, input logic [17:0] pr);
        apb(1'b1, 8'h08, {24'h0, en[14:7]});
        apb(1'b1, 8'h0c, {29'h0, en[17:15]});
        apb(1'b1, 8'h10, {25'h0, pr[6:0]});
        apb(1'b1, 8'h14, {24'h0, pr[14:7]});
        apb(1'b1, 8'h18, {29'h0, pr[17:15]});
        apb(1'b1, 8'h04, {24'h0, g, en[6:0]});
    endtask

    // Waits for a call, checks it, then lets the core acknowledge it
    task automatic take_call(input logic [4:0] i, input logic hi);
        waited = 0;
        while (call_o.call_req !== 1'b1) begin
            @(posedge pclk);
            waited++;
        end
        chk({call_o.call_hi, call_o.call_idx, call_o.call_vec},
            {hi, i, 16'h0003 + {8'h0, i, 3'h0}});
        while (call_o.call_req === 1'b1) @(posedge pclk);
    endtask

    task automatic ret();
        return_from_irq_instr_req <= 1'b1;
        @(posedge pclk);
        return_from_irq_instr_req <= 1'b0;
        while (!(core_i.instr_done === 1'b1 && core_i.instr_is_return_from_irq_instr === 1'b1)) @(posedge pclk);
    endtask

    task automatic quiet();
        repeat (20) begin
            @(posedge pclk);
            chk({31'h0, call_o.call_req}, 32'h0);
        end
    endtask

    task automatic pulse(input logic [17:0] ev);
        src_event <= ev;
        @(posedge pclk);
        src_event <= 18'h0;
    endtask

    task automatic final_report();
        $display("comparisons %0d, num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report();
    end

    // Main sequence
    initial begin
        apb_i       = '0;
        src_event   = '0;
        ext_pin     = 2'h0;
        slow        = 1'b0;
        return_from_irq_instr_req    = 1'b0;
        num_errors  = 0;
        comparisons = 0;
        seed        = 8'h44;
        presetn     = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // All registers come up zero: disabled, low priority
        for (int a = 0; a < 32; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk(q, 32'h0);
        end
        apb(1'b1, 8'h20, 32'hffffffff);
        apb(1'b0, 8'h20, 32'h0);
        chk({q[30:0], err}, 32'h1);
        // Flag set while its own enable is off, then left pending while global is off
        cfg(1'b1, 18'h3ffdf, 18'h0);
        pulse(18'h00020);
        quiet();
        cfg(1'b0, 18'h3ffff, 18'h0);
        apb(1'b1, 8'h04, 32'h7f);
        quiet();
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h20);
        cfg(1'b1, 18'h3ffff, 18'h0);
        take_call(5'h5, 1'b0);
        apb(1'b0, 8'h1c, 32'h0);
        // Low level in service; the index of the taken call stays visible
        chk(q, 32'h52);
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h20);
        ret();
        take_call(5'h5, 1'b0);
        apb(1'b1, 8'h00, 32'h0);
        ret();
        quiet();
        // Shortest path from event to call
        pulse(18'h00080);
        take_call(5'h7, 1'b0);
        chk(waited, 32'h3);
        apb(1'b1, 8'h00, 32'h0);
        ret();
        // Levels and ties, preemption and its refusal
        cfg(1'b1, 18'h3ffff, 18'h00200);
        apb(1'b1, 8'h00, 32'h1210);
        take_call(5'h9, 1'b1);
        apb(1'b1, 8'h00, 32'h1010);
        quiet();
        ret();
        take_call(5'h4, 1'b0);
        apb(1'b1, 8'h00, 32'h200);
        take_call(5'h9, 1'b1);
        apb(1'b1, 8'h00, 32'h0);
        ret();
        ret();
        quiet();
        // External pin edge
        cfg(1'b1, 18'h3ffff, 18'h0);
        ext_pin <= 2'h2;
        take_call(5'h2, 1'b0);
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0);
        ret();
        ext_pin <= 2'h0;
        // Random software-raised flags, random level, prompt then slow core
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            idx  = 5'(seed % 8'h12);
            slow <= (k > 5);
            cfg(1'b1, 18'h3ffff, {17'h0, seed[7]} << idx);
            apb(1'b1, 8'h00, 32'h1 << idx);
            take_call(idx, seed[7]);
            apb(1'b0, 8'h00, 32'h0);
            chk(q, after_ack(idx));
            apb(1'b1, 8'h00, 32'h0);
            ret();
        end
        quiet();
        final_report();
    end
endmodule
